/* rtl/arah_pkg.sv */
/*
 * arah_pkg: constants and carriers for the drive register access holding block.
 * assumes an 8-bit microcontroller external data space with 16-bit addresses.
 */
package arah_pkg;

	// register addresses in external data space
	localparam logic [15:0] ADDR_HOLD_LOW  = 16'hF0D2;
	localparam logic [15:0] ADDR_HOLD_HIGH = 16'hF0D3;
	localparam logic [15:0] ADDR_CONTROL   = 16'hF0D4;

	// reset values, and the data an unmapped read returns
	localparam logic [7:0] RST_HOLD_LOW  = 8'h00;
	localparam logic [7:0] RST_HOLD_HIGH = 8'h00;
	localparam logic [3:0] RST_SELECT    = 4'h0;
	localparam logic       RST_REQUEST   = 1'b0;
	localparam logic [7:0] RST_RDATA     = 8'h00;
	localparam logic [7:0] RD_UNMAPPED   = 8'h00;

	// access control field positions
	localparam int CTL_SECT_MSB  = 0;
	localparam int CTL_FLUSH     = 1;
	localparam int CTL_RD_REQ    = 2;
	localparam int CTL_WR_REQ    = 3;
	localparam int CTL_SEL_LSB   = 4;
	localparam int CTL_SEL_MSB   = 7;

	// target select: top bit picks command block, data register is 0h there
	localparam int          SEL_BLOCK_BIT = 3;
	localparam logic [3:0]  SEL_DATA_REG  = 4'h8;
	localparam int          SEL_ADDR_MSB  = 2;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        cs0;
		logic        cs1;
		logic [2:0]  addr;
		logic [15:0] wdata;
	} arah_drv_req_t;

	typedef struct packed {
		logic        done;
		logic [15:0] rdata;
	} arah_drv_rsp_t;

	localparam arah_drv_req_t RST_DRV_REQ = '0;

endpackage

/* rtl/arah_top.sv */
/*
 * arah_top: holding register pair and access control register for single
 * drive register reads and writes, seen by the microcontroller in its
 * external data space.
 * assumes a bus cycle engine on sys_clk that runs a cycle while rd or wr is
 * high and pulses done for one cycle at its end, with read data alongside.
 * assumes the microcontroller strobes run on sys_clk, one cycle per access.
 * assumes sector_count_msb comes from a register on sys_clk, so it is not
 * synchronised; the sector buffer logic that takes the flush pulse is outside.
 */
// Notes on behaviour
// - a drive register write sends the value already held in the 16-bit holding pair.
// - when a drive register read completes the returned value is loaded into the pair.
// - a read of any register other than the data register updates only the low byte.
// - a read of the data register captures all sixteen returned bits.
// - the low holding byte is read/write at its own address and resets to zero.
// - the high holding byte is read/write at a separate address and resets to zero.
// - setting the read bit runs a read, stores the result, then clears both request bits.
// - setting the write bit sends the pair to the selected register, then clears both bits.
// - setting read and write together performs the read only and drops the write.
// - select top bit 0 with low bits 6h uses chip select 1, top bit 1 uses chip select 0.
`timescale 1ns/1ps
module arah_top (
	input  wire logic                   sys_clk,
	input  wire logic                   nrst,
	input  wire logic [15:0]            xdata_addr,
	input  wire logic                   xdata_wr,
	input  wire logic                   xdata_rd,
	input  wire logic [7:0]             xdata_wdata,
	output logic      [7:0]             xdata_rdata,
	output arah_pkg::arah_drv_req_t     drv_req,
	input  wire arah_pkg::arah_drv_rsp_t drv_rsp,
	input  wire logic                   sector_count_msb,
	output logic                        sector_buffer_flush
);

	// decoded register bus strobes
	logic                    wr_low;
	logic                    wr_high;
	logic                    wr_ctl;
	logic                    rd_low;
	logic                    rd_high;
	logic                    rd_ctl;
	logic                    rd_done;
	logic                    any_done;

	// holding pair
	logic [7:0]              hold_low;
	logic [7:0]              hold_high;
	logic [7:0]              next_hold_low;
	logic [7:0]              next_hold_high;

	// access control register
	logic [3:0]              target_register_select;
	logic                    bus_read_request;
	logic                    bus_write_request;
	logic [3:0]              next_select;
	logic                    next_rd;
	logic                    next_wr;
	logic                    next_flush;
	logic [7:0]              ctl_readback;

	// outputs to the drive side and to the microcontroller
	arah_pkg::arah_drv_req_t next_req;
	logic [7:0]              next_rdata;

	// address decode of both strobes, and the end of a drive cycle
	always_comb begin
		wr_low   = xdata_wr && (xdata_addr == arah_pkg::ADDR_HOLD_LOW);
		wr_high  = xdata_wr && (xdata_addr == arah_pkg::ADDR_HOLD_HIGH);
		wr_ctl   = xdata_wr && (xdata_addr == arah_pkg::ADDR_CONTROL);
		rd_low   = xdata_rd && (xdata_addr == arah_pkg::ADDR_HOLD_LOW);
		rd_high  = xdata_rd && (xdata_addr == arah_pkg::ADDR_HOLD_HIGH);
		rd_ctl   = xdata_rd && (xdata_addr == arah_pkg::ADDR_CONTROL);
		any_done = drv_rsp.done;
		rd_done  = drv_rsp.done && bus_read_request;
	end

	// low holding byte: a drive read result wins over a microcontroller write
	always_comb begin
		next_hold_low = hold_low;
		if (wr_low) begin
			next_hold_low = xdata_wdata;
		end
		if (rd_done) begin
			next_hold_low = drv_rsp.rdata[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			hold_low <= arah_pkg::RST_HOLD_LOW;
		end else begin
			hold_low <= next_hold_low;
		end
	end

	// high holding byte: only a data register read loads it from the drive
	always_comb begin
		next_hold_high = hold_high;
		if (wr_high) begin
			next_hold_high = xdata_wdata;
		end
		if (rd_done && (target_register_select == arah_pkg::SEL_DATA_REG)) begin
			next_hold_high = drv_rsp.rdata[15:8];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			hold_high <= arah_pkg::RST_HOLD_HIGH;
		end else begin
			hold_high <= next_hold_high;
		end
	end

	// target register select
	always_comb begin
		next_select = target_register_select;
		if (wr_ctl) begin
			next_select = xdata_wdata[arah_pkg::CTL_SEL_MSB:arah_pkg::CTL_SEL_LSB];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			target_register_select <= arah_pkg::RST_SELECT;
		end else begin
			target_register_select <= next_select;
		end
	end

	// request bits clear when a cycle ends; a control write in that cycle wins
	always_comb begin
		next_rd = bus_read_request;
		next_wr = bus_write_request;
		if (any_done) begin
			next_rd = 1'b0;
			next_wr = 1'b0;
		end
		if (wr_ctl) begin
			next_rd = xdata_wdata[arah_pkg::CTL_RD_REQ];
			next_wr = xdata_wdata[arah_pkg::CTL_WR_REQ]
				&& !xdata_wdata[arah_pkg::CTL_RD_REQ];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			bus_read_request  <= arah_pkg::RST_REQUEST;
			bus_write_request <= arah_pkg::RST_REQUEST;
		end else begin
			bus_read_request  <= next_rd;
			bus_write_request <= next_wr;
		end
	end

	// flush is a one-cycle pulse after a control write with its bit set
	always_comb begin
		next_flush = 1'b0;
		if (wr_ctl) begin
			next_flush = xdata_wdata[arah_pkg::CTL_FLUSH];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sector_buffer_flush <= arah_pkg::RST_REQUEST;
		end else begin
			sector_buffer_flush <= next_flush;
		end
	end

	// drive side request, registered so every field comes from a flop
	always_comb begin
		next_req       = '0;
		next_req.rd    = next_rd;
		next_req.wr    = next_wr;
		next_req.cs0   = next_select[arah_pkg::SEL_BLOCK_BIT];
		next_req.cs1   = !next_select[arah_pkg::SEL_BLOCK_BIT];
		next_req.addr  = next_select[arah_pkg::SEL_ADDR_MSB:0];
		next_req.wdata = {next_hold_high, next_hold_low};
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			drv_req <= arah_pkg::RST_DRV_REQ;
		end else begin
			drv_req <= next_req;
		end
	end

	// control register as the microcontroller sees it; flush always reads 0
	always_comb begin
		ctl_readback = '0;
		ctl_readback[arah_pkg::CTL_SEL_MSB:arah_pkg::CTL_SEL_LSB] =
			target_register_select;
		ctl_readback[arah_pkg::CTL_WR_REQ]   = bus_write_request;
		ctl_readback[arah_pkg::CTL_RD_REQ]   = bus_read_request;
		ctl_readback[arah_pkg::CTL_FLUSH]    = 1'b0;
		ctl_readback[arah_pkg::CTL_SECT_MSB] = sector_count_msb;
	end

	// read data holds until the next read strobe; unmapped reads return zero
	always_comb begin
		next_rdata = xdata_rdata;
		if (rd_low) begin
			next_rdata = hold_low;
		end else if (rd_high) begin
			next_rdata = hold_high;
		end else if (rd_ctl) begin
			next_rdata = ctl_readback;
		end else if (xdata_rd) begin
			next_rdata = arah_pkg::RD_UNMAPPED;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			xdata_rdata <= arah_pkg::RST_RDATA;
		end else begin
			xdata_rdata <= next_rdata;
		end
	end

endmodule

/* test/arah_top_asserts.sv */
/* arah_chk: assertions on arah_top ports; attached by the bind at the foot. */
`timescale 1ns/1ps
module arah_chk (
	input wire logic                    sys_clk,
	input wire logic                    nrst,
	input wire logic                    xdata_wr,
	input wire logic [15:0]             xdata_addr,
	input wire logic [7:0]              xdata_wdata,
	input wire arah_pkg::arah_drv_req_t drv_req,
	input wire arah_pkg::arah_drv_rsp_t drv_rsp
);
	wire logic m = drv_rsp.done && !xdata_wr, r = m && drv_req.rd;
	wire logic c = xdata_wr && xdata_addr == arah_pkg::ADDR_CONTROL;
	wire logic x = drv_req.cs0 && drv_req.addr == 3'h0;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_lo; r |=> drv_req.wdata[7:0] == $past(drv_rsp.rdata[7:0]); endproperty
	a_lo: assert property (p_lo) else $error("low byte");
	property p_hi; r && !x |=> $stable(drv_req.wdata[15:8]); endproperty
	a_hi: assert property (p_hi) else $error("high byte");
	property p_all; r && x |=> drv_req.wdata == $past(drv_rsp.rdata); endproperty
	a_all: assert property (p_all) else $error("word");
	property p_clr; m |=> !drv_req.rd && !drv_req.wr; endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_wr; c && xdata_wdata[3:2] == 2'h2 |=> drv_req.wr && !drv_req.rd; endproperty
	a_wr: assert property (p_wr) else $error("write");
	property p_rw; c && xdata_wdata[3:2] == 2'h3 |=> drv_req.rd && !drv_req.wr; endproperty
	a_rw: assert property (p_rw) else $error("both");
	property p_cs; c |=> drv_req.cs0 ^ drv_req.cs1 && drv_req.cs0 == $past(xdata_wdata[7]); endproperty
	a_cs: assert property (p_cs) else $error("select");
	property p_keep; drv_req.wr && !xdata_wr && !drv_rsp.done |=> $stable(drv_req.wdata); endproperty
	a_keep: assert property (p_keep) else $error("wdata");
endmodule
bind arah_top arah_chk i_arah_chk (.*);

/* test/arah_drive_model.sv */
/* arah_drive_model: drive end of the link; bench sets answer delay and read value. */
`timescale 1ns/1ps
module arah_drive_model (
	input wire logic                    sys_clk,
	input wire arah_pkg::arah_drv_req_t drv_req,
	input wire logic [3:0]              dly,
	input wire logic [15:0]             rval,
	output arah_pkg::arah_drv_rsp_t     drv_rsp = '0,
	output logic [15:0]                 last_wr = '0
);
	logic [3:0] n = 4'h0;
	wire logic b = drv_req.rd || drv_req.wr, e = b && n == dly;
	always @(posedge sys_clk) begin
		n <= b ? n + 4'h1 : 4'h0;
		drv_rsp <= {e, drv_req.rd && e ? rval : ~drv_rsp.rdata};
		if (drv_req.wr && !drv_req.rd && e) last_wr <= drv_req.wdata;
	end
endmodule

/* test/test_arah_top.sv */
/* test_arah_top: directed bench for arah_top with the drive model on its link. */
`timescale 1ns/1ps
module test_arah_top;
	logic sys_clk = 0, nrst = 0, xdata_wr = 0, xdata_rd = 0, sector_count_msb = 0;
	logic [15:0] xdata_addr = '0, rval = '0, last_wr;
	logic [7:0] xdata_wdata = '0, xdata_rdata, lo;
	logic [3:0] dly = '0;
	logic sector_buffer_flush;
	logic [15:0] flushes = '0;
	arah_pkg::arah_drv_req_t drv_req;
	arah_pkg::arah_drv_rsp_t drv_rsp;
	int err_count = 0, total_checks = 0;
	always #4 sys_clk = ~sys_clk;
	arah_top i_arah_top (.*);
	arah_drive_model i_arah_drive_model (.*);
	always @(posedge sys_clk) if (sector_buffer_flush) flushes <= flushes + 16'h1;
	task automatic chk(input logic [15:0] g, e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
		@(posedge sys_clk) {xdata_addr, xdata_wr, xdata_rd, xdata_wdata} <= {a, w, !w, d};
		@(posedge sys_clk) {xdata_wr, xdata_rd} <= 2'h0;
		@(posedge sys_clk) #1;
	endtask
	task automatic pair(input logic [15:0] e);
		bus(arah_pkg::ADDR_HOLD_LOW, 0, 0);
		lo = xdata_rdata;
		bus(arah_pkg::ADDR_HOLD_HIGH, 0, 0);
		chk({xdata_rdata, lo}, e);
	endtask
	task automatic go(input logic [7:0] c, input logic [15:0] v, input logic [3:0] n);
		logic [15:0] f;
		f = flushes;
		{rval, dly} = {v, n};
		bus(arah_pkg::ADDR_CONTROL, 1, c);
		chk({11'h0, drv_req.cs0, drv_req.cs1, drv_req.addr}, {11'h0, c[7], !c[7], c[6:4]});
		repeat (40) if (drv_req.rd || drv_req.wr) #8;
		bus(arah_pkg::ADDR_CONTROL, 0, 0);
		chk({8'h00, xdata_rdata}, {8'h00, c[7:4], 3'h0, sector_count_msb});
		chk(flushes, f + {15'h0, c[1]});
	endtask
	task automatic t_regs;
		pair(16'h0000);
		bus(arah_pkg::ADDR_HOLD_LOW, 1, 8'hA5);
		bus(arah_pkg::ADDR_HOLD_HIGH, 1, 8'h3C);
		bus(16'hF0E0, 1, 8'h77);
		pair(16'h3CA5);
		$display("regs done");
	endtask
	task automatic t_rw;
		go(8'h18, 16'h0000, 4'h0);
		chk(last_wr, 16'h3CA5);
		go(8'h84, 16'hABCD, 4'h5);
		pair(16'hABCD);
		@(posedge sys_clk) sector_count_msb <= 1;
		go(8'h6E, 16'h1234, 4'hC);
		pair(16'hAB34);
		chk(last_wr, 16'h3CA5);
		$display("transfers done");
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		nrst <= 1;
		t_regs;
		t_rw;
		stop_test;
	end
	initial begin
		#20000 err_count++;
		stop_test;
	end
endmodule
